// >>> rtl/imc_defines.svh
// Register offsets, field positions and reset values for the interrupt slot block
`ifndef IMC_DEFINES_SVH
`define IMC_DEFINES_SVH
`define IMC_SLOTS_OFFSET 32'hFFFFE020
`define IMC_SLOT_LEVEL_LSB 0
`define IMC_SLOT_DMA_BIT 4
`define IMC_SLOT_ACT_LSB 5
`define IMC_SLOT_USED_MASK 8'h77
`define IMC_SLOT_RESET 8'h00
`define IMC_ACT_HIGH_LEVEL 2'h1
`define IMC_FIRST_SOURCE 6'h20
`endif

// >>> rtl/imc_pkg.sv
// Types shared by the interrupt slot block
package imc_pkg;
  typedef enum logic [1:0] {RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2} axi_resp_t;
  typedef enum {WR_IDLE, WR_RESP} wr_state_t;
endpackage

// >>> rtl/imc_slot.sv
// One per-source slot: request detection and routing to interrupt or DMA
`timescale 1ns/1ns
`include "imc_defines.svh"
module imc_slot (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Configuration and request
  input wire logic [7:0] cfg_i,
  input wire logic req_i,
  // Routed outputs
  output logic [2:0] int_level_o,
  output logic [7:0] dma_trig_o
);
  logic [1:0] act;
  logic dma_sel;
  logic [2:0] sel;
  logic active;

  // Field extraction
  assign act = cfg_i[`IMC_SLOT_ACT_LSB +: 2];
  assign dma_sel = cfg_i[`IMC_SLOT_DMA_BIT];
  assign sel = cfg_i[`IMC_SLOT_LEVEL_LSB +: 3];
  // Only high level is a defined mode; other codes leave the request inactive
  assign active = (act == `IMC_ACT_HIGH_LEVEL) && req_i;

  // Registered routing outputs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_level_o <= 3'h0;
      dma_trig_o <= 8'h00;
    end else begin
      int_level_o <= (active && !dma_sel) ? sel : 3'h0;
      dma_trig_o <= (active && dma_sel) ? (8'h01 << sel) : 8'h00;
    end
  end

  // Routing checks
  a_dma_excl: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (dma_trig_o != 8'h00) |-> (int_level_o == 3'h0))
    else $error("dma trigger and interrupt both active");
  a_level_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (active && !dma_sel) |=> (int_level_o == $past(sel)))
    else $error("interrupt level does not follow field");
  a_chan_onehot: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (active && dma_sel) |=> (dma_trig_o == (8'h01 << $past(sel))))
    else $error("wrong dma channel triggered");
  a_inactive_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !active |=> (int_level_o == 3'h0 && dma_trig_o == 8'h00))
    else $error("output without active request");
endmodule

// >>> rtl/imc_top.sv
// Interrupt mode control for sources 32 and 33 behind an AXI4-Lite slave
// Operation
// - Two-bit active field; 01 means high level
// - DMA select routes source to DMA, not interrupt
// - Level field: 000 disables, else level 1-7
// - With DMA set, field picks channel 0-7
// - Next byte repeats layout for next source
`timescale 1ns/1ns
`include "imc_defines.svh"
module imc_top #(
  parameter int NUM_SLOTS = 2
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // AXI4-Lite write address and data
  input wire logic [31:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read
  input wire logic [31:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Peripheral request lines, one per source
  input wire logic [NUM_SLOTS-1:0] REQ_I,
  // Routed outputs, three level bits and eight DMA triggers per source
  output logic [3*NUM_SLOTS-1:0] INT_LEVEL_O,
  output logic [8*NUM_SLOTS-1:0] DMA_TRIG_O
);
  // ************************************************
  // Elaboration check
  // ************************************************
  if (NUM_SLOTS < 1 || NUM_SLOTS > 4) begin : g_bad_slots
    $error("NUM_SLOTS must be 1 to 4");
  end
  if (`IMC_SLOT_ACT_LSB + 2 > 8 || `IMC_SLOT_DMA_BIT > 7) begin : g_bad_layout
    $error("slot fields must fit in one byte");
  end

  // ************************************************
  // Address decode
  // ************************************************
  // Only bits 31:2 are compared; byte lanes inside the word follow the strobes
  function automatic logic hit(input logic [31:0] addr);
    logic [31:0] base;
    base = `IMC_SLOTS_OFFSET;
    hit = (addr[31:2] == base[31:2]);
  endfunction

  // ************************************************
  // Slot field decode
  // ************************************************
  // Shared by the routing checks so each reads the same bit positions
  function automatic logic [1:0] act_field(input logic [7:0] cfg);
    act_field = cfg[`IMC_SLOT_ACT_LSB +: 2];
  endfunction

  function automatic logic dma_field(input logic [7:0] cfg);
    dma_field = cfg[`IMC_SLOT_DMA_BIT];
  endfunction

  function automatic logic [2:0] sel_field(input logic [7:0] cfg);
    sel_field = cfg[`IMC_SLOT_LEVEL_LSB +: 3];
  endfunction

  logic [7:0] slot [NUM_SLOTS];
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  imc_pkg::wr_state_t wr_state;
  logic [31:0] rd_word;

  // Accept address and data in either order, one write at a time
  assign AWREADY_O = !aw_held && (wr_state == imc_pkg::WR_IDLE);
  assign WREADY_O = !w_held && (wr_state == imc_pkg::WR_IDLE);
  assign do_write = aw_held && w_held && (wr_state == imc_pkg::WR_IDLE);

  // Write address capture
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
    end else if (AWVALID_I && AWREADY_O) begin
      aw_held <= 1'b1;
      aw_addr <= AWADDR_I;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (WVALID_I && WREADY_O) begin
      w_held <= 1'b1;
      w_data <= WDATA_I;
      w_strb <= WSTRB_I;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Write response state
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_state <= imc_pkg::WR_IDLE;
      BRESP_O <= imc_pkg::RESP_OKAY;
    end else begin
      case (wr_state)
        imc_pkg::WR_IDLE: begin
          if (do_write) begin
            wr_state <= imc_pkg::WR_RESP;
            BRESP_O <= hit(aw_addr) ? imc_pkg::RESP_OKAY : imc_pkg::RESP_SLVERR;
          end
        end
        imc_pkg::WR_RESP: begin
          if (BREADY_I) begin
            wr_state <= imc_pkg::WR_IDLE;
          end
        end
        default: begin
          wr_state <= imc_pkg::WR_IDLE;
        end
      endcase
    end
  end
  assign BVALID_O = (wr_state == imc_pkg::WR_RESP);

  // ************************************************
  // Slot storage, one byte per source
  // ************************************************
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    // Reset value is not an operating mode; software must set 01 first
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        slot[s] <= `IMC_SLOT_RESET;
      end else if (do_write && hit(aw_addr) && w_strb[s]) begin
        slot[s] <= w_data[8*s +: 8] & `IMC_SLOT_USED_MASK;
      end
    end

    imc_slot u_slot (
      .clock_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .cfg_i(slot[s]),
      .req_i(REQ_I[s]),
      .int_level_o(INT_LEVEL_O[3*s +: 3]),
      .dma_trig_o(DMA_TRIG_O[8*s +: 8])
    );

    a_unused_zero: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (slot[s] & ~`IMC_SLOT_USED_MASK) == 8'h00)
      else $error("unused slot bit set");

    // Stored byte reaches this source's pins one cycle later
    a_level_route: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (act_field(slot[s]) == `IMC_ACT_HIGH_LEVEL && REQ_I[s] && !dma_field(slot[s]))
      |=> (INT_LEVEL_O[3*s +: 3] == $past(sel_field(slot[s]))))
      else $error("interrupt level pin does not follow slot");
    // Channel code maps straight onto one trigger bit
    a_chan_route: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (act_field(slot[s]) == `IMC_ACT_HIGH_LEVEL && REQ_I[s] && dma_field(slot[s]))
      |=> (DMA_TRIG_O[8*s +: 8] == (8'h01 << $past(sel_field(slot[s])))))
      else $error("dma trigger pin does not follow slot");

    // DMA select steers the request away from the interrupt path
    a_dma_no_level: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      dma_field(slot[s]) |=> (INT_LEVEL_O[3*s +: 3] == 3'h0))
      else $error("interrupt raised with dma select set");
    a_level_no_dma: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      !dma_field(slot[s]) |=> (DMA_TRIG_O[8*s +: 8] == 8'h00))
      else $error("dma triggered with dma select clear");

    // Level code zero keeps the interrupt off, even with the line high
    a_zero_disables: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (sel_field(slot[s]) == 3'h0) |=> (INT_LEVEL_O[3*s +: 3] == 3'h0))
      else $error("level zero did not disable interrupt");

    // Any other active code, or a low line, keeps both paths quiet
    a_act_gate: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (act_field(slot[s]) != `IMC_ACT_HIGH_LEVEL || !REQ_I[s])
      |=> (INT_LEVEL_O[3*s +: 3] == 3'h0 && DMA_TRIG_O[8*s +: 8] == 8'h00))
      else $error("output without high level request");

    // At most one channel per source, so the DMA side never sees a pair
    a_chan_onehot0: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      $onehot0(DMA_TRIG_O[8*s +: 8]))
      else $error("more than one dma channel triggered");

    // Storage moves only on a mapped write with this byte's strobe
    a_slot_hold: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      !(do_write && hit(aw_addr) && w_strb[s]) |=> $stable(slot[s]))
      else $error("slot changed without its write");
    // Unused bits are masked on the way in, never stored
    a_slot_store: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (do_write && hit(aw_addr) && w_strb[s])
      |=> (slot[s] == ($past(w_data[8*s +: 8]) & `IMC_SLOT_USED_MASK)))
      else $error("slot byte not stored as masked");
  end

  // Read word assembly; bytes past the last slot read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      rd_word[8*s +: 8] = slot[s];
    end
  end

  // ************************************************
  // Read channel
  // ************************************************
  assign ARREADY_O = !RVALID_O;

  // Read data registered one cycle after address acceptance
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= imc_pkg::RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      RVALID_O <= 1'b1;
      RDATA_O <= hit(ARADDR_I) ? rd_word : 32'h0000_0000;
      RRESP_O <= hit(ARADDR_I) ? imc_pkg::RESP_OKAY : imc_pkg::RESP_SLVERR;
    end else if (RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end

  a_write_resp: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    do_write |=> BVALID_O)
    else $error("write response missing");
  a_read_unused: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O && hit(ARADDR_I)) |=> ((RDATA_O & 32'h8888_8888) == 32'h0000_0000))
    else $error("unused bit read nonzero");
  a_slot_write: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (do_write && hit(aw_addr) && w_strb[0]) |=> (slot[0] == ($past(w_data[7:0]) & `IMC_SLOT_USED_MASK)))
    else $error("slot byte not stored");

  // ************************************************
  // Bus handshake checks
  // ************************************************
  // Readies fall while a response waits, so nothing can overwrite it
  a_bvalid_hold: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (BVALID_O && !BREADY_I) |=> (BVALID_O && $stable(BRESP_O)))
    else $error("write response dropped or changed before taken");
  // The read side holds data and response code together
  a_rvalid_hold: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (RVALID_O && !RREADY_I) |=> (RVALID_O && $stable(RDATA_O) && $stable(RRESP_O)))
    else $error("read response dropped or changed before taken");

  // Each response clears on the edge that hands it over
  a_bvalid_clear: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (BVALID_O && BREADY_I) |=> !BVALID_O)
    else $error("write response stayed after handshake");
  a_rvalid_clear: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (RVALID_O && RREADY_I) |=> !RVALID_O)
    else $error("read response stayed after handshake");

  // Two cycles for a write taken in one beat, one for a read
  a_write_latency: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O) |-> ##2 BVALID_O)
    else $error("write response late");
  a_read_latency: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O) |=> RVALID_O)
    else $error("read response late");

  // Unmapped writes answer with an error and mapped ones with okay
  a_write_miss: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (do_write && !hit(aw_addr)) |=> (BRESP_O == imc_pkg::RESP_SLVERR))
    else $error("unmapped write not refused");
  a_write_hit: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (do_write && hit(aw_addr)) |=> (BRESP_O == imc_pkg::RESP_OKAY))
    else $error("mapped write refused");

  // Reads return the assembled word, or zero with an error when unmapped
  a_read_hit: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O && hit(ARADDR_I))
    |=> (RRESP_O == imc_pkg::RESP_OKAY && RDATA_O == $past(rd_word)))
    else $error("mapped read wrong");
  // Zero data keeps a stray read from looking like a configured slot
  a_read_miss: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O && !hit(ARADDR_I))
    |=> (RRESP_O == imc_pkg::RESP_SLVERR && RDATA_O == 32'h0000_0000))
    else $error("unmapped read not refused");

  // Bytes past the last slot read zero, whatever the slot count
  a_upper_zero: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O && hit(ARADDR_I)) |=> ((RDATA_O >> (8 * NUM_SLOTS)) == 32'h0000_0000))
    else $error("byte past last slot read nonzero");
endmodule

// >>> verif/imc_src_model.sv
// Peripheral request source model driving the level request lines
`timescale 1ns/1ns
module imc_src_model #(
  parameter int N = 2
) (
  // Clock
  input wire logic clock_i,
  // Request lines, level, active high
  output logic [N-1:0] req_o
);
  // Lines idle low until a peripheral flags a request
  initial req_o = '0;
  // Changes just after an edge, as a registered peripheral flag would
  task automatic drive(input logic [N-1:0] v);
    @(posedge clock_i);
    req_o <= v;
  endtask
endmodule

// >>> verif/interrupt_slot_mode_control_test.sv
// Self-checking bench for the interrupt slot mode control block
`timescale 1ns/1ns
`include "imc_defines.svh"
module interrupt_slot_mode_control_test;
  // Bus, request and routed signals
  logic CLOCK_I = 0, RST_N_I = 0, AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0, RREADY_I = 0;
  logic [31:0] AWADDR_I = 0, WDATA_I = 0, ARADDR_I = 0, RDATA_O, d;
  logic [3:0] WSTRB_I = 0, m;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, a;
  logic [1:0] BRESP_O, RRESP_O, REQ_I;
  logic [5:0] INT_LEVEL_O;
  logic [15:0] DMA_TRIG_O;
  int fails = 0, checked = 0, cycles = 0, i, s;
  bit [7:0] cfg [2];
  imc_top uut (.CLOCK_I, .RST_N_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I, .WSTRB_I, .WVALID_I,
    .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O,
    .RVALID_O, .RREADY_I, .REQ_I, .INT_LEVEL_O, .DMA_TRIG_O);
  imc_src_model src (.clock_i(CLOCK_I), .req_o(REQ_I));
  always #10 CLOCK_I = ~CLOCK_I;
  // Ceiling well above the roughly 350 cycles the run needs
  always @(posedge CLOCK_I) if (++cycles == 5000) begin
    fails++;
    test_done();
  end
  task automatic test_done();
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [31:0] ad, dd, input logic [3:0] st, input logic [1:0] r);
    bit pa, pw;
    pa = 1;
    pw = 1;
    @(posedge CLOCK_I);
    AWADDR_I <= ad;
    WDATA_I <= dd;
    WSTRB_I <= st;
    AWVALID_I <= 1;
    WVALID_I <= 1;
    BREADY_I <= 1;
    while (pa | pw) begin
      @(posedge CLOCK_I);
      if (pa && AWREADY_O === 1'b1) begin
        pa = 0;
        AWVALID_I <= 0;
      end
      if (pw && WREADY_O === 1'b1) begin
        pw = 0;
        WVALID_I <= 0;
      end
    end
    while (BVALID_O !== 1'b1) @(posedge CLOCK_I);
    BREADY_I <= 0;
    chk("bresp", BRESP_O, r);
  endtask
  task automatic rd(input logic [31:0] ad, exp, input logic [1:0] r);
    @(posedge CLOCK_I);
    ARADDR_I <= ad;
    ARVALID_I <= 1;
    RREADY_I <= 1;
    do @(posedge CLOCK_I); while (ARREADY_O !== 1'b1);
    ARVALID_I <= 0;
    do @(posedge CLOCK_I); while (RVALID_O !== 1'b1);
    RREADY_I <= 0;
    chk("rdata", RDATA_O, exp);
    chk("rresp", RRESP_O, r);
  endtask
  // Main sequence: reset, unmapped access, every level and channel code with active 01, then random slots
  initial begin
    void'($urandom(47084));
    repeat (20) @(posedge CLOCK_I);
    RST_N_I <= 1;
    rd(`IMC_SLOTS_OFFSET, 0, imc_pkg::RESP_OKAY);
    wr(`IMC_SLOTS_OFFSET + 4, 32'hFFFFFFFF, 4'hF, imc_pkg::RESP_SLVERR);
    rd(`IMC_SLOTS_OFFSET, 0, imc_pkg::RESP_OKAY);
    rd(`IMC_SLOTS_OFFSET + 4, 0, imc_pkg::RESP_SLVERR);
    for (i = 0; i < 40; i++) begin
      d = $urandom;
      m = i < 16 ? 4'hF : 4'($urandom);
      // Unused bits set high on purpose; they must not stick
      if (i < 16) d[15:0] = {2{1'b1, 2'b01, i[3], 1'b1, i[2:0]}};
      wr(`IMC_SLOTS_OFFSET, d, m, imc_pkg::RESP_OKAY);
      for (s = 0; s < 2; s++) if (m[s]) cfg[s] = d[8*s+:8] & `IMC_SLOT_USED_MASK;
      src.drive(i < 16 ? 2'h3 : 2'($urandom));
      rd(`IMC_SLOTS_OFFSET, {cfg[1], cfg[0]}, imc_pkg::RESP_OKAY);
      for (s = 0; s < 2; s++) begin
        a = cfg[s][6:5] == 2'b01 && REQ_I[s];
        chk("level", INT_LEVEL_O[3*s+:3], (a && !cfg[s][4]) ? cfg[s][2:0] : 0);
        chk("dma", DMA_TRIG_O[8*s+:8], (a && cfg[s][4]) ? 8'h01 << cfg[s][2:0] : 0);
      end
    end
    test_done();
  end
endmodule
